// ### rtl/asrw_regs.svh
// register offsets, field positions and reset values for the receiver
`ifndef ASRW_REGS_SVH
`define ASRW_REGS_SVH
// byte offsets on the apb bus
`define ASRW_RCSTA_OFF 8'h00
`define ASRW_RXDATA_OFF 8'h04
`define ASRW_TXSTA_OFF 8'h08
`define ASRW_BAUDCON_OFF 8'h0C
`define ASRW_HIGH_SPEED_BAUD_SELECT_OFF 8'h10
`define ASRW_BRGL_OFF 8'h14
`define ASRW_IRQ_STAT_OFF 8'h18
`define ASRW_IRQ_MASK_OFF 8'h1C
`define ASRW_CTRL_OFF 8'h20
// receive_status_control fields
`define ASRW_RC_SERIAL_PORT_ON 7
`define ASRW_RC_RX9 6
`define ASRW_RC_CONTINUOUS_RECEIVE_ON 4
`define ASRW_RC_ADDRESS_MATCH_FILTER 3
`define ASRW_RC_FRAMING_ERROR_FLAG 2
`define ASRW_RC_OVERRUN_ERROR_FLAG 1
`define ASRW_RC_RECEIVED_NINTH_BIT 0
// transmit_status_control fields
`define ASRW_TX_SYNC 4
`define ASRW_TX_HIGH_SPEED_BAUD_SELECT 2
// baud_control fields
`define ASRW_BC_RCIDL 6
`define ASRW_BC_WIDE_BAUD_DIVISOR_SELECT 3
`define ASRW_BC_WUE 1
// interrupt status bits
`define ASRW_IRQ_RX 0
`define ASRW_IRQ_WAKE 1
`define ASRW_IRQ_ERR 2
// reset values and x16 oversample factor
`define ASRW_RC_RST 8'h00
`define ASRW_TX_RST 8'h02
`define ASRW_BC_RST 8'h40
`define ASRW_OVS 16
`endif

// ### rtl/asrw_pkg.sv
// types shared by the serial receiver
package asrw_pkg;
	typedef enum logic [1:0] {
		ASRW_IDLE,
		ASRW_START,
		ASRW_DATA,
		ASRW_STOP
	} asrw_state_t;
	typedef enum logic [1:0] {
		ASRW_WK_OFF,
		ASRW_WK_ARMED,
		ASRW_WK_LOW
	} asrw_wake_t;
endpackage : asrw_pkg

// ### rtl/asrw_receiver.sv
// asynchronous serial receiver with address filter and wake on edge
`timescale 1ns/1ps
`include "asrw_regs.svh"

module asrw_receiver (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial line and power state
	input wire logic serial_in_pin,
	input wire logic sleep_mode,
	// interrupt
	output logic irq
);
	logic [7:0] rcsta_q, txsta_q, baudcon_q, high_speed_baud_select_q, brgl_q;
	logic [2:0] irq_stat_q, irq_mask_q;
	logic receive_irq_enable_q;
	logic [7:0] rxdata_q;
	logic received_ninth_bit_q, framing_error_flag_q, overrun_error_flag_q, receive_flag_q, wake_flag_q;
	logic rx_s1_q, rx_s2_q, rx_prev_q;
	logic [15:0] brg_cnt_q;
	logic [5:0] pre_cnt_q;
	logic tick16;
	logic [3:0] os_cnt_q;
	logic [3:0] bit_idx_q;
	logic [8:0] shift_q;
	asrw_pkg::asrw_state_t state_q;
	asrw_pkg::asrw_wake_t wake_q;
	logic rx_on, wake_on, rd_data, wr_en, rd_en;
	logic char_done, char_ok, char_keep, rx_fall, rx_rise;
	logic [3:0] nbits;
	logic [5:0] pre_max;

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign rd_data = rd_en && (paddr == `ASRW_RXDATA_OFF);
	assign wake_on = baudcon_q[`ASRW_BC_WUE];
	assign rx_on = rcsta_q[`ASRW_RC_SERIAL_PORT_ON] && !txsta_q[`ASRW_TX_SYNC] &&
		rcsta_q[`ASRW_RC_CONTINUOUS_RECEIVE_ON] && !sleep_mode && !wake_on;

	// two-stage sync of the line; stage one read only by stage two
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
			rx_prev_q <= 1'b1;
		end else begin
			rx_s1_q <= serial_in_pin;
			rx_s2_q <= rx_s1_q;
			rx_prev_q <= rx_s2_q;
		end
	end
	assign rx_fall = rx_prev_q && !rx_s2_q;
	assign rx_rise = !rx_prev_q && rx_s2_q;

	// prescale picks x16 tick from divisor and select bits
	always_comb begin
		unique case ({baudcon_q[`ASRW_BC_WIDE_BAUD_DIVISOR_SELECT], txsta_q[`ASRW_TX_HIGH_SPEED_BAUD_SELECT]})
			2'b00: pre_max = 6'd3;
			2'b11: pre_max = 6'd0;
			default: pre_max = 6'd1;
		endcase
	end
	// divisor counter then prescaler; tick is one x16 sample slot
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			brg_cnt_q <= 16'h0000;
			pre_cnt_q <= 6'h00;
		end else if (!rx_on || (state_q == asrw_pkg::ASRW_IDLE)) begin
			brg_cnt_q <= 16'h0000;
			pre_cnt_q <= 6'h00;
		end else if (brg_cnt_q >= {(baudcon_q[`ASRW_BC_WIDE_BAUD_DIVISOR_SELECT] ?
				high_speed_baud_select_q : 8'h00), brgl_q}) begin
			brg_cnt_q <= 16'h0000;
			pre_cnt_q <= (pre_cnt_q >= pre_max) ? 6'h00 : pre_cnt_q + 6'd1;
		end else begin
			brg_cnt_q <= brg_cnt_q + 16'd1;
		end
	end
	assign tick16 = rx_on && (state_q != asrw_pkg::ASRW_IDLE) &&
		(brg_cnt_q >= {(baudcon_q[`ASRW_BC_WIDE_BAUD_DIVISOR_SELECT] ? high_speed_baud_select_q : 8'h00),
		brgl_q}) && (pre_cnt_q >= pre_max);

	// nine bits when ninth-bit receive set
	assign nbits = rcsta_q[`ASRW_RC_RX9] ? 4'd9 : 4'd8;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= asrw_pkg::ASRW_IDLE;
			os_cnt_q <= 4'h0;
			bit_idx_q <= 4'h0;
			shift_q <= 9'h000;
		end else if (!rx_on) begin
			state_q <= asrw_pkg::ASRW_IDLE;
		end else begin
			unique case (state_q)
				asrw_pkg::ASRW_IDLE: begin
					os_cnt_q <= 4'h0;
					if (!rx_s2_q) begin
						state_q <= asrw_pkg::ASRW_START;
					end
				end
				asrw_pkg::ASRW_START: if (tick16) begin
					os_cnt_q <= os_cnt_q + 4'd1;
					// mid start bit: reject glitch or begin data
					if (os_cnt_q == 4'd7) begin
						os_cnt_q <= 4'h0;
						bit_idx_q <= 4'h0;
						state_q <= rx_s2_q ? asrw_pkg::ASRW_IDLE :
							asrw_pkg::ASRW_DATA;
					end
				end
				asrw_pkg::ASRW_DATA: if (tick16) begin
					os_cnt_q <= os_cnt_q + 4'd1;
					if (os_cnt_q == 4'd15) begin
						// lsb first into the top, shifted down
						shift_q <= {rx_s2_q, shift_q[8:1]};
						bit_idx_q <= bit_idx_q + 4'd1;
						if (bit_idx_q == nbits - 4'd1) begin
							state_q <= asrw_pkg::ASRW_STOP;
						end
					end
				end
				asrw_pkg::ASRW_STOP: if (tick16) begin
					os_cnt_q <= os_cnt_q + 4'd1;
					if (os_cnt_q == 4'd15) begin
						state_q <= asrw_pkg::ASRW_IDLE;
					end
				end
			endcase
		end
	end
	assign char_done = tick16 && (state_q == asrw_pkg::ASRW_STOP) &&
		(os_cnt_q == 4'd15);
	// filter only with nine bits and filter set
	assign char_ok = !(rcsta_q[`ASRW_RC_RX9] && rcsta_q[`ASRW_RC_ADDRESS_MATCH_FILTER] &&
		!(rcsta_q[`ASRW_RC_RX9] ? shift_q[8] : 1'b0));
	assign char_keep = char_done && char_ok;

	// receive buffer and error flags; overrun keeps old data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxdata_q <= 8'h00;
			received_ninth_bit_q <= 1'b0;
			framing_error_flag_q <= 1'b0;
			overrun_error_flag_q <= 1'b0;
		end else if (!rcsta_q[`ASRW_RC_CONTINUOUS_RECEIVE_ON]) begin
			framing_error_flag_q <= 1'b0;
			overrun_error_flag_q <= 1'b0;
		end else if (char_keep) begin
			if (receive_flag_q && !rd_data) begin
				overrun_error_flag_q <= 1'b1;
			end else begin
				rxdata_q <= rcsta_q[`ASRW_RC_RX9] ? shift_q[7:0] :
					shift_q[8:1];
				// ninth bit kept for status read
				received_ninth_bit_q <= rcsta_q[`ASRW_RC_RX9] ? shift_q[8] : 1'b0;
				framing_error_flag_q <= !rx_s2_q;
			end
		end
	end

	// enable arms, falling edge wakes, rising edge clears enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_q <= asrw_pkg::ASRW_WK_OFF;
		end else if (!wake_on) begin
			wake_q <= asrw_pkg::ASRW_WK_OFF;
		end else begin
			unique case (wake_q)
				asrw_pkg::ASRW_WK_OFF: wake_q <= asrw_pkg::ASRW_WK_ARMED;
				asrw_pkg::ASRW_WK_ARMED: if (rx_fall) begin
					wake_q <= asrw_pkg::ASRW_WK_LOW;
				end
				asrw_pkg::ASRW_WK_LOW: if (rx_rise) begin
					wake_q <= asrw_pkg::ASRW_WK_OFF;
				end
				default: wake_q <= asrw_pkg::ASRW_WK_OFF;
			endcase
		end
	end

	// flag set per char; set beats clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			receive_flag_q <= 1'b0;
			wake_flag_q <= 1'b0;
		end else begin
			if (char_keep && !(receive_flag_q && !rd_data)) begin
				receive_flag_q <= 1'b1;
			end else if (wake_on && wake_q == asrw_pkg::ASRW_WK_ARMED &&
					rx_fall) begin
				receive_flag_q <= 1'b1;
				wake_flag_q <= 1'b1;
			end else if (rd_data) begin
				receive_flag_q <= 1'b0;
				wake_flag_q <= 1'b0;
			end
		end
	end

	// control registers written by software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rcsta_q <= `ASRW_RC_RST;
			txsta_q <= `ASRW_TX_RST;
			baudcon_q <= `ASRW_BC_RST;
			high_speed_baud_select_q <= 8'h00;
			brgl_q <= 8'h00;
			irq_mask_q <= 3'h0;
			receive_irq_enable_q <= 1'b0;
		end else begin
			if (wr_en) begin
				unique case (paddr)
					`ASRW_RCSTA_OFF: rcsta_q <= pwdata[7:0];
					`ASRW_TXSTA_OFF: txsta_q <= pwdata[7:0];
					`ASRW_BAUDCON_OFF: baudcon_q <= pwdata[7:0];
					`ASRW_HIGH_SPEED_BAUD_SELECT_OFF: high_speed_baud_select_q <= pwdata[7:0];
					`ASRW_BRGL_OFF: brgl_q <= pwdata[7:0];
					`ASRW_IRQ_MASK_OFF: irq_mask_q <= pwdata[2:0];
					`ASRW_CTRL_OFF: receive_irq_enable_q <= pwdata[0];
					default: ;
				endcase
			end
			// hardware clear wins over a write
			if (wake_q == asrw_pkg::ASRW_WK_LOW && rx_rise) begin
				baudcon_q[`ASRW_BC_WUE] <= 1'b0;
			end
		end
	end

	// sticky events, write one to clear, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= 3'h0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~((wr_en &&
				paddr == `ASRW_IRQ_STAT_OFF) ? pwdata[2:0] : 3'h0)) |
				{char_done && overrun_error_flag_q == 1'b0 && !rx_s2_q,
				wake_q == asrw_pkg::ASRW_WK_ARMED && rx_fall,
				char_keep};
		end
	end
	// irq from masked status, or from receive flag with the receive enable
	assign irq = (|(irq_stat_q & irq_mask_q)) ||
		(receive_flag_q && receive_irq_enable_q);

	// read mux; status bits are live, reserved read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				`ASRW_RCSTA_OFF: prdata <= {24'h0, rcsta_q[7:3], framing_error_flag_q,
					overrun_error_flag_q, received_ninth_bit_q};
				`ASRW_RXDATA_OFF: prdata <= {24'h0, rxdata_q};
				`ASRW_TXSTA_OFF: prdata <= {24'h0, txsta_q};
				`ASRW_BAUDCON_OFF: prdata <= {24'h0, baudcon_q[7],
					state_q == asrw_pkg::ASRW_IDLE, baudcon_q[5:3],
					1'b0, baudcon_q[1:0]};
				`ASRW_HIGH_SPEED_BAUD_SELECT_OFF: prdata <= {24'h0, high_speed_baud_select_q};
				`ASRW_BRGL_OFF: prdata <= {24'h0, brgl_q};
				`ASRW_IRQ_STAT_OFF: prdata <= {29'h0, irq_stat_q};
				`ASRW_IRQ_MASK_OFF: prdata <= {29'h0, irq_mask_q};
				`ASRW_CTRL_OFF: prdata <= {30'h0, wake_flag_q,
					receive_irq_enable_q};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end
	// one-cycle access phase; unmapped reads zero with slverr
	assign pready = 1'b1;
	assign pslverr = psel && penable && (paddr > `ASRW_CTRL_OFF ||
		paddr[1:0] != 2'b00);
endmodule : asrw_receiver

// ### verif/asrw_receiver_chk.sv
// port assertions for the serial receiver
`timescale 1ns/1ps
module asrw_receiver_chk (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// line and interrupt
	input wire logic serial_in_pin,
	input wire logic irq
);
	logic [7:0] age_q;
	logic line_q;
	logic acc;
	assign acc = psel && penable;
	// cycles since the line moved; saturates so it never wraps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			age_q <= 8'hFF;
			line_q <= 1'b1;
		end else begin
			line_q <= serial_in_pin;
			if (line_q != serial_in_pin)
				age_q <= 8'h00;
			else if (age_q != 8'hFF)
				age_q <= age_q + 8'h01;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_zero_wait: assert property (acc |-> pready)
		else $error("ready low in access");
	a_bad_addr_err: assert property (acc && paddr > 8'h20 |-> pslverr)
		else $error("no error on unmapped");
	a_good_addr_ok: assert property
		(acc && paddr <= 8'h20 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("error on mapped");
	a_err_in_access: assert property (!acc |-> !pslverr)
		else $error("error outside access");
	a_bad_addr_zero: assert property
		(acc && !pwrite && paddr > 8'h20 |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	a_upper_zero: assert property
		(acc && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_data_holds: assert property
		(!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data moved");
	a_flag_cause: assert property
		($rose(irq) |-> age_q < 8'hC8 || $past(acc && pwrite))
		else $error("interrupt without cause");
endmodule : asrw_receiver_chk
bind asrw_receiver asrw_receiver_chk u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.serial_in_pin(serial_in_pin), .irq(irq));

// ### verif/asrw_remote_tx.sv
// remote serial transmitter driving the receive line
`timescale 1ns/1ps
module asrw_remote_tx #(
	parameter int BIT_CYC = 16
) (
	// clock and line
	input wire logic clk,
	output logic line
);
	// line rests at mark level between frames
	initial line = 1'b1;
	// lsb first; stop level free so framing faults can be made
	task automatic send(input logic [8:0] d, input int nb, input logic stop);
		for (int i = -1; i <= nb; i++) begin
			@(posedge clk);
			line <= (i < 0) ? 1'b0 : (i == nb) ? stop : d[i];
			repeat (BIT_CYC - 1) @(posedge clk);
		end
		@(posedge clk);
		line <= 1'b1;
		repeat (2 * BIT_CYC) @(posedge clk);
	endtask : send
endmodule : asrw_remote_tx

// ### verif/testbench.sv
// register level tests of the serial receiver
`timescale 1ns/1ps
`include "asrw_regs.svh"
module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic line;
	logic sleep_mode = 1'b0;
	logic irq;
	logic [31:0] rdat;
	logic rerr;
	int errors = 0;
	int checks_done = 0;
	int cyc = 0;
	always #50 pclk = ~pclk;
	asrw_receiver u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.serial_in_pin(line), .sleep_mode(sleep_mode), .irq(irq));
	asrw_remote_tx u_tx (.clk(pclk), .line(line));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	// one apb transfer; waits for ready, then idles a cycle
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask : rd
	// irq is looked at mid-cycle, where it has settled
	task automatic irq_is(input logic e);
		@(negedge pclk);
		chk({31'h0, irq}, {31'h0, e});
		@(posedge pclk);
	endtask : irq_is
	task automatic frame(input logic [8:0] d, input int nb, input logic e);
		u_tx.send(d, nb, 1'b1);
		irq_is(e);
	endtask : frame
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(`ASRW_RCSTA_OFF, 32'h00);
		rd(`ASRW_TXSTA_OFF, 32'h02);
		rd(`ASRW_BAUDCON_OFF, 32'h40);
		rd(8'h24, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		apb(1'b1, `ASRW_TXSTA_OFF, 32'h04);
		apb(1'b1, `ASRW_BAUDCON_OFF, 32'h08);
		apb(1'b1, `ASRW_BRGL_OFF, 32'h00);
		apb(1'b1, `ASRW_RCSTA_OFF, 32'h90);
		$display("setup done");
		frame(9'h0A5, 8, 1'b0);
		rd(`ASRW_IRQ_STAT_OFF, 32'h01);
		apb(1'b1, `ASRW_IRQ_MASK_OFF, 32'h01);
		irq_is(1'b1);
		apb(1'b1, `ASRW_IRQ_STAT_OFF, 32'h01);
		irq_is(1'b0);
		apb(1'b1, `ASRW_IRQ_MASK_OFF, 32'h00);
		apb(1'b1, `ASRW_CTRL_OFF, 32'h01);
		irq_is(1'b1);
		rd(`ASRW_RCSTA_OFF, 32'h90);
		rd(`ASRW_RXDATA_OFF, 32'hA5);
		irq_is(1'b0);
		$display("char test done");
		apb(1'b1, `ASRW_RCSTA_OFF, 32'h80);
		frame(9'h03C, 8, 1'b0);
		apb(1'b1, `ASRW_RCSTA_OFF, 32'hD8);
		frame(9'h055, 9, 1'b0);
		frame(9'h1AA, 9, 1'b1);
		rd(`ASRW_RCSTA_OFF, 32'hD9);
		rd(`ASRW_RXDATA_OFF, 32'hAA);
		apb(1'b1, `ASRW_RCSTA_OFF, 32'hD0);
		frame(9'h033, 9, 1'b1);
		rd(`ASRW_RCSTA_OFF, 32'hD0);
		rd(`ASRW_RXDATA_OFF, 32'h33);
		$display("filter test done");
		apb(1'b1, `ASRW_RCSTA_OFF, 32'h90);
		u_tx.send(9'h0F0, 8, 1'b0);
		rd(`ASRW_RCSTA_OFF, 32'h94);
		rd(`ASRW_RXDATA_OFF, 32'hF0);
		apb(1'b1, `ASRW_RCSTA_OFF, 32'h80);
		rd(`ASRW_RCSTA_OFF, 32'h80);
		rd(`ASRW_IRQ_STAT_OFF, 32'h05);
		apb(1'b1, `ASRW_RCSTA_OFF, 32'h90);
		$display("error test done");
		sleep_mode <= 1'b1;
		frame(9'h05A, 8, 1'b0);
		apb(1'b1, `ASRW_BAUDCON_OFF, 32'h0A);
		frame(9'h000, 8, 1'b1);
		rd(`ASRW_BAUDCON_OFF, 32'h48);
		rd(`ASRW_CTRL_OFF, 32'h03);
		sleep_mode <= 1'b0;
		apb(1'b0, `ASRW_RXDATA_OFF, 32'h0);
		irq_is(1'b0);
		frame(9'h069, 8, 1'b1);
		rd(`ASRW_RXDATA_OFF, 32'h69);
		rd(`ASRW_IRQ_STAT_OFF, 32'h07);
		$display("wake test done");
		frame(9'h011, 8, 1'b1);
		u_tx.send(9'h022, 8, 1'b1);
		rd(`ASRW_RCSTA_OFF, 32'h92);
		rd(`ASRW_RXDATA_OFF, 32'h11);
		apb(1'b1, `ASRW_RCSTA_OFF, 32'h80);
		rd(`ASRW_RCSTA_OFF, 32'h80);
		$display("overrun test done");
		close_out;
	end
	// a hung run ends here as a failure
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			close_out;
		end
	end
	task automatic close_out;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out
endmodule : testbench
